// ### verilog/adc_ctrl_regs.svh
/*
 * register offsets, field positions, result width and timing counts of the
 * converter control block.
 * assumes inclusion by bare name from any file that needs the numbers.
 */
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// ****************************************************************
// register word indices (byte addresses 0,4,8; printed offsets 0,1,2 are word indices)
// ****************************************************************
`define CSR_INDEX        2'h0
`define RES_HIGH_INDEX   2'h1
`define RES_LOW_INDEX    2'h2
`define ADDR_W           4

// ****************************************************************
// control/status fields
// ****************************************************************
`define CSR_DONE_BIT     7
`define CSR_SPEED_BIT    6
`define CSR_ON_BIT       5
`define CSR_CH_HI        3
`define CSR_CH_LO        0

// ****************************************************************
// converter timing
// ****************************************************************
`define RES_BITS         10
`define RES_MSB          4'h9
`define SAMPLE_TICKS     4'h2
`define DIV_SLOW         2'h3
`define DIV_FAST         2'h1
`define RES_FULL         10'h3FF

`endif

// ### verilog/adc_ctrl_pkg.sv
/*
 * types shared by the converter control files.
 * assumes the constants header is used for every number.
 */
package adc_ctrl_pkg;
    typedef enum logic [1:0] {
        st_off,
        st_sample,
        st_convert
    } conv_state_t;
endpackage

// ### verilog/sar_if.sv
/*
 * interface between the sequencer and the analog core (comparator, dac).
 * assumes one clock; comparator output is already synchronised.
 */
`timescale 1ns/1ns
`default_nettype none
interface sar_if;
    logic       tick;
    logic       start;
    logic [9:0] trial;
    logic       cmp_high;
    logic       busy;
    logic       done;
    logic [9:0] result;
    modport seq  (input tick, input start, input cmp_high,
                  output trial, output busy, output done, output result);
    modport ctrl (output tick, output start, output cmp_high,
                  input trial, input busy, input done, input result);
endinterface
`default_nettype wire

// ### verilog/clk_divider.sv
/*
 * converter clock tick: cpu clock divided by 4 or by 2.
 * assumes speed select may change at any time; the count restarts cleanly.
 */
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_regs.svh"
module clk_divider (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    input  wire logic fast,
    output logic      tick
);
    typedef struct packed {
        logic [1:0] cnt;
        logic       tick;
    } div_state_t;

    div_state_t s_q;
    div_state_t s_d;

    always_comb begin
        logic [1:0] lim;
        lim = fast ? `DIV_FAST : `DIV_SLOW;
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.cnt = 2'h0;
        end else if (s_q.cnt >= lim) begin
            s_d.cnt  = 2'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 2'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule
`default_nettype wire

// ### verilog/sar_sequencer.sv
/*
 * successive approximation sequencer: sample phase then one bit per two ticks,
 * msb first.
 * assumes cmp_high is high when the input is at or above the trial level.
 */
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_regs.svh"
module sar_sequencer (
    input  wire logic clk,
    input  wire logic rst,
    sar_if.seq        sar
);
    typedef struct packed {
        adc_ctrl_pkg::conv_state_t st;
        logic [3:0]                bit_idx;
        logic [9:0]                acc;
        logic [9:0]                result;
        logic                      done;
        logic                      settle;
    } seq_state_t;

    seq_state_t s_q;
    seq_state_t s_d;

    function automatic logic [9:0] onehot(input logic [3:0] i);
        onehot = 10'h001 << i;
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (sar.start) begin
            // abort restarts the sampling phase from scratch
            s_d.st      = adc_ctrl_pkg::st_sample;
            s_d.bit_idx = `SAMPLE_TICKS;
            s_d.acc     = 10'h000;
            s_d.settle  = 1'b0;
        end else if (sar.tick) begin
            case (s_q.st)
                adc_ctrl_pkg::st_sample: begin
                    if (s_q.bit_idx == 4'h0) begin
                        s_d.st      = adc_ctrl_pkg::st_convert;
                        s_d.bit_idx = `RES_MSB;
                    end else begin
                        s_d.bit_idx = s_q.bit_idx - 4'h1;
                    end
                end
                adc_ctrl_pkg::st_convert: begin
                    if (!s_q.settle) begin
                        // the synchronised comparator trails a new trial by
                        // two clocks, as long as one fast tick: wait a tick
                        s_d.settle = 1'b1;
                    end else begin
                        s_d.settle = 1'b0;
                        // keep the trial bit only if input reaches it;
                        // binary search on a held sample is monotonic
                        if (!sar.cmp_high) begin
                            s_d.acc = s_q.acc & ~onehot(s_q.bit_idx);
                        end
                        if (s_q.bit_idx == 4'h0) begin
                            s_d.result  = s_d.acc;
                            s_d.done    = 1'b1;
                            s_d.st      = adc_ctrl_pkg::st_sample;
                            s_d.bit_idx = `SAMPLE_TICKS;
                            s_d.acc     = 10'h000;
                        end else begin
                            s_d.bit_idx = s_q.bit_idx - 4'h1;
                            s_d.acc = s_d.acc | onehot(s_q.bit_idx - 4'h1);
                        end
                    end
                end
                default: begin
                    s_d.st = adc_ctrl_pkg::st_off;
                end
            endcase
            if (s_q.st == adc_ctrl_pkg::st_sample && s_q.bit_idx == 4'h0) begin
                s_d.acc = onehot(`RES_MSB);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sar.trial  = s_q.acc;
    assign sar.busy   = (s_q.st == adc_ctrl_pkg::st_convert);
    assign sar.done   = s_q.done;
    assign sar.result = s_q.result;
endmodule
`default_nettype wire

// ### verilog/sar_adc_control.sv
/*
 * control and result logic of a 10-bit successive approximation converter
 * with a 16-way input multiplexer, reached over avalon-mm.
 * assumes an external comparator (cmp_high_pin) and resistor dac driven by
 * dac_level and mux_sel; the comparator output is asynchronous.
 */
// Our own choices: the register addresses and register access over Avalon-MM.
//
// Behaviour
// - 10-bit successive approximation result from one of 16 multiplexed inputs.
// - result never moves against the direction of the input.
// - input above high reference gives high byte FF, low byte 03.
// - input below low reference gives both bytes zero.
// - every finished conversion lands in the high and low result bytes.
// - converter-on bit starts continuous conversions of the selected input.
// - done flag rises at the end of each conversion with result available.
// - reading high byte clears done; reading low byte leaves it.
// - results are overwritten by each conversion; read both in time.
// - changing channel aborts, clears done and restarts on new input.
// - clearing converter-on stops conversions and saves power.
// - cpu wait mode does not affect the converter.
// - halt disables the converter; results need settling after wake.
// - analog pins still read as digital inputs.
// - any write to the control/status register clears done; a write with byteenable[0] low is ignored here and leaves done.
// - bit 7 read-only done; speed, on, zero bit, channel read/write.
// - speed bit selects cpu clock divided by 4 or by 2.
// - high byte holds bits 9:2; low byte bits 1:0, rest zero.
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_regs.svh"
module sar_adc_control (
    input  wire logic        clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // power modes
    input  wire logic        cpu_wait,
    input  wire logic        cpu_halt,
    // analog core
    input  wire logic        cmp_high_pin,
    output logic [3:0]       mux_sel,
    output logic [9:0]       dac_level,
    output logic             analog_enable,
    output logic             sample_hold
);
    typedef struct packed {
        logic        speed;
        logic        on;
        logic [3:0]  ch;
        logic        done;
        logic [9:0]  result;
        logic        ack;
        logic [31:0] rdata;
        logic        cmp_s1;
        logic        cmp_s2;
        logic        start;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;

    sar_if sar ();

    logic running;
    logic tick;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [1:0] reg_index(input logic [3:0] a);
        reg_index = a[3:2];
    endfunction

    function automatic logic is_aligned(input logic [3:0] a);
        is_aligned = (a[1:0] == 2'h0);
    endfunction

    // ****************************************************************
    // converter core
    // ****************************************************************
    // halt gates the converter off; wait has no input here at all
    // cpu_wait is deliberately unused in the gating
    assign running = s_q.on && !cpu_halt;

    clk_divider u_div (
        .clk  (clk),
        .rst  (rst),
        .run  (running),
        .fast (s_q.speed),
        .tick (tick)
    );

    assign sar.tick     = tick;
    assign sar.start    = s_q.start;
    assign sar.cmp_high = s_q.cmp_s2;

    sar_sequencer u_seq (
        .clk (clk),
        .rst (rst),
        .sar (sar)
    );

    // ****************************************************************
    // register file and control
    // ****************************************************************
    always_comb begin
        logic        acc_ok;
        logic        wr_csr;
        logic        rd_high;
        logic [3:0]  new_ch;
        logic        ch_changed;
        logic        hw_set;
        acc_ok     = (read || write) && !s_q.ack && is_aligned(address);
        wr_csr     = acc_ok && write && reg_index(address) == `CSR_INDEX
                     && byteenable[0];
        rd_high    = acc_ok && read && reg_index(address) == `RES_HIGH_INDEX;
        new_ch     = writedata[`CSR_CH_HI:`CSR_CH_LO];
        ch_changed = wr_csr && (new_ch != s_q.ch);
        s_d        = s_q;
        // comparator crosses from the analog domain
        s_d.cmp_s1 = cmp_high_pin;
        s_d.cmp_s2 = s_q.cmp_s1;
        s_d.ack    = (read || write) && !s_q.ack;
        s_d.start  = 1'b0;
        // a result finishing under a restart pulse is of the old channel
        hw_set     = sar.done && running && !ch_changed && !s_q.start;
        if (wr_csr) begin
            s_d.speed = writedata[`CSR_SPEED_BIT];
            s_d.on    = writedata[`CSR_ON_BIT];
            s_d.ch    = new_ch;
            // turning on, or a new channel, restarts from sampling
            if (ch_changed || (writedata[`CSR_ON_BIT] && !s_q.on)) begin
                s_d.start = 1'b1;
            end
        end
        if (wr_csr || rd_high) begin
            s_d.done = 1'b0;
        end
        if (hw_set) begin
            // saturated codes fall out of the search: all ones above the
            // high reference, zero below the low one
            s_d.result = sar.result;
            s_d.done   = 1'b1;
        end
        if (cpu_halt && s_q.on) begin
            s_d.start = 1'b1;
        end
        s_d.rdata = 32'h0000_0000;
        if (acc_ok && read) begin
            case (reg_index(address))
                `CSR_INDEX: begin
                    s_d.rdata[`CSR_DONE_BIT]  = s_q.done;
                    s_d.rdata[`CSR_SPEED_BIT] = s_q.speed;
                    s_d.rdata[`CSR_ON_BIT]    = s_q.on;
                    s_d.rdata[`CSR_CH_HI:`CSR_CH_LO] = s_q.ch;
                end
                `RES_HIGH_INDEX: begin
                    s_d.rdata[7:0] = s_q.result[9:2];
                end
                `RES_LOW_INDEX: begin
                    s_d.rdata[1:0] = s_q.result[1:0];
                end
                default: begin
                    s_d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // one wait cycle per access; the answer stands in the ack cycle
    assign waitrequest   = (read || write) && !s_q.ack;
    assign readdata      = s_q.rdata;
    assign mux_sel       = s_q.ch;
    assign dac_level     = sar.trial;
    assign analog_enable = running;
    // sample switch closed outside bit trials; pins keep digital path
    assign sample_hold   = running && !sar.busy;
endmodule
`default_nettype wire

// ### tb/sar_adc_props.sv
/* bus and control assertions of the converter block.
   assumes bind onto sar_adc_control, one clock, async reset. */
`timescale 1ns/1ns
`default_nettype none
module sar_adc_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        cpu_wait,
    input wire logic        cpu_halt,
    input wire logic        cmp_high_pin,
    input wire logic [3:0]  mux_sel,
    input wire logic [9:0]  dac_level,
    input wire logic        analog_enable,
    input wire logic        sample_hold
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic rd_ok;
    logic csr_wr;
    assign rd_ok = read && !waitrequest;
    assign csr_wr = write && waitrequest && address == 4'h0 && byteenable[0];
    // ****************************************************************
    // bus answers, register contents and converter power-down
    // ****************************************************************
    a_ack_next: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
    a_low_upper: assert property (
        rd_ok && address == 4'h8 |-> readdata[31:2] == 30'h0)
        else $error("low byte upper bits set");
    a_high_upper: assert property (
        rd_ok && address == 4'h4 |-> readdata[31:8] == 24'h0)
        else $error("high byte upper bits set");
    a_csr_reserved: assert property (
        rd_ok && address == 4'h0 |-> !readdata[4] && readdata[31:8] == 24'h0)
        else $error("reserved csr bits set");
    a_unmapped_zero: assert property (
        rd_ok && !(address inside {4'h0, 4'h4, 4'h8}) |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    a_mux_follow: assert property (
        csr_wr |=> mux_sel == $past(writedata[3:0]))
        else $error("channel not taken");
    a_off_stops: assert property (
        csr_wr && !writedata[5] |-> ##2 !analog_enable)
        else $error("converter still on");
    a_halt_off: assert property (
        cpu_halt ##1 cpu_halt |-> !analog_enable)
        else $error("converter on in halt");
    a_idle_quiet: assert property (
        !analog_enable ##1 !analog_enable |-> !sample_hold)
        else $error("sampling while off");
endmodule
bind sar_adc_control sar_adc_props u_props (.clk(clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .cpu_wait(cpu_wait), .cpu_halt(cpu_halt),
    .cmp_high_pin(cmp_high_pin), .mux_sel(mux_sel), .dac_level(dac_level),
    .analog_enable(analog_enable), .sample_hold(sample_hold));
`default_nettype wire

// ### tb/analog_model.sv
/* comparator and input multiplexer standing for the analog core.
   assumes the bench sets ain_level per channel and holds it steady. */
`timescale 1ns/1ns
`default_nettype none
module analog_model (
    input wire logic       clk,
    input wire logic [3:0] mux_sel,
    input wire logic [9:0] dac_level,
    input wire logic       analog_enable,
    output logic           cmp_high
);
    int   ain_level [16];
    logic idle_q = 1'b0;
    // powered-down comparator gives no steady level
    always_ff @(posedge clk) idle_q <= ~idle_q;
    // levels outside 0..3FF clamp naturally in the compare
    assign cmp_high = analog_enable ?
        (ain_level[mux_sel] >= int'(dac_level)) : idle_q;
endmodule
`default_nettype wire

// ### tb/sar_adc_control_tb_top.sv
/* self-checking bench of the converter block.
   assumes the analog model answers the dac trials. */
`timescale 1ns/1ns
`default_nettype none
module sar_adc_control_tb_top;
    logic        clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
    logic        cpu_wait = 1'b0, cpu_halt = 1'b0;
    logic [3:0]  address = 4'h0, byteenable = 4'h0, mux_sel;
    logic [31:0] writedata = 32'h0, readdata, rdq;
    logic        waitrequest, cmp_high_pin, analog_enable, sample_hold;
    logic [9:0]  dac_level;
    int          mismatches = 0, cmp_count = 0, cyc = 0, cs, cf;
    always #5 clk = ~clk;
    sar_adc_control u_dut (.clk(clk), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .cpu_wait(cpu_wait), .cpu_halt(cpu_halt),
        .cmp_high_pin(cmp_high_pin), .mux_sel(mux_sel),
        .dac_level(dac_level), .analog_enable(analog_enable),
        .sample_hold(sample_hold));
    analog_model u_model (.clk(clk), .mux_sel(mux_sel),
        .dac_level(dac_level), .analog_enable(analog_enable),
        .cmp_high(cmp_high_pin));
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task chk(input string what, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // called just after a rising edge; the request stands until waitrequest
    // is sampled low at a rising edge, then one idle edge separates calls
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
             input logic [3:0] be);
        address <= a; write <= wr; read <= !wr;
        writedata <= {24'h0, d}; byteenable <= be;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        rdq = readdata;
        read <= 1'b0; write <= 1'b0;
        @(posedge clk);
    endtask
    task wait_done(output int cy);
        int t0, n;
        t0 = cyc; n = 0;
        rdq = 32'h0;
        while (rdq[7] !== 1'b1 && n < 200) begin
            bus(1'b0, 4'h0, 8'h00, 4'h0);
            n++;
        end
        cy = cyc - t0;
        chk("done set", rdq[7], 1'b1);
    endtask
    task read_result(input logic [9:0] exp);
        bus(1'b0, 4'h8, 8'h00, 4'h0);
        chk("low byte", rdq, {30'h0, exp[1:0]});
        bus(1'b0, 4'h0, 8'h00, 4'h0);
        chk("done after low", rdq[7], 1'b1);
        bus(1'b0, 4'h4, 8'h00, 4'h0);
        chk("high byte", rdq, {24'h0, exp[9:2]});
        bus(1'b0, 4'h0, 8'h00, 4'h0);
        chk("done after high", rdq[7], 1'b0);
    endtask
    task convert(input logic [3:0] ch, input int lvl, input logic [9:0] exp,
                 input logic fast, output int cy);
        u_model.ain_level[ch] = lvl;
        bus(1'b1, 4'h0, {1'b0, fast, 2'h2, ch}, 4'h1);
        bus(1'b0, 4'h0, 8'h00, 4'h0);
        chk("done after write", rdq[7], 1'b0);
        chk("csr", rdq, {25'h0, fast, 2'h2, ch});
        chk("mux", mux_sel, ch);
        wait_done(cy);
        read_result(exp);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_reset;
        logic [3:0] a [4] = '{4'h0, 4'h4, 4'h8, 4'hC};
        foreach (a[i]) begin
            bus(1'b0, a[i], 8'h00, 4'h0);
            chk("reset value", rdq, 32'h0);
        end
        $display("test reset done");
    endtask
    task t_table;
        logic [3:0] ch [5] = '{4'h3, 4'h5, 4'h9, 4'hF, 4'h0};
        int         lv [5] = '{'h2A7, 2000, -5, 'h155, 'h200};
        logic [9:0] ex [5] = '{10'h2A7, 10'h3FF, 10'h000, 10'h155, 10'h200};
        foreach (ch[i]) convert(ch[i], lv[i], ex[i], i[0], cs);
        convert(4'h1, 'h100, 10'h100, 1'b0, cs);
        convert(4'h2, 'h101, 10'h101, 1'b1, cf);
        chk("fast clock quicker", cf < cs, 1'b1);
        $display("test table done");
    endtask
    task t_continuous;
        u_model.ain_level[2] = 'h0F0;
        wait_done(cs);
        bus(1'b0, 4'h4, 8'h00, 4'h0);
        wait_done(cs);
        read_result(10'h0F0);
        wait_done(cs);
        bus(1'b0, 4'h4, 8'h00, 4'h0);
        chk("high only", rdq, 32'h3C);
        bus(1'b0, 4'h0, 8'h00, 4'h0);
        chk("done after high only", rdq[7], 1'b0);
        wait_done(cs);
        bus(1'b1, 4'h0, 8'h62, 4'h1);
        bus(1'b0, 4'h0, 8'h00, 4'h0);
        chk("done after csr write", rdq[7], 1'b0);
        $display("test continuous done");
    endtask
    task t_power;
        cpu_wait <= 1'b1;
        wait_done(cs);
        cpu_wait <= 1'b0;
        bus(1'b0, 4'h4, 8'h00, 4'h0);
        cpu_halt <= 1'b1;
        repeat (100) @(posedge clk);
        chk("halt off", analog_enable, 1'b0);
        bus(1'b0, 4'h0, 8'h00, 4'h0);
        chk("no done in halt", rdq[7], 1'b0);
        cpu_halt <= 1'b0;
        wait_done(cs);
        read_result(10'h0F0);
        bus(1'b1, 4'h0, 8'h02, 4'h1);
        repeat (100) @(posedge clk);
        bus(1'b0, 4'h0, 8'h00, 4'h0);
        chk("off csr", rdq, 32'h02);
        chk("off enable", analog_enable, 1'b0);
        $display("test power done");
    endtask
    task t_refused;
        bus(1'b1, 4'h0, 8'h3F, 4'h0);
        bus(1'b1, 4'h0, 8'h17, 4'h1);
        bus(1'b1, 4'hC, 8'hAA, 4'hF);
        bus(1'b0, 4'h0, 8'h00, 4'h0);
        chk("reserved bit", rdq, 32'h07);
        bus(1'b0, 4'hC, 8'h00, 4'h0);
        chk("unmapped", rdq, 32'h0);
        $display("test refused done");
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            print_verdict;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_table;
        t_continuous;
        t_power;
        t_refused;
        print_verdict;
    end
endmodule
`default_nettype wire
